// >>> hdl/udcc_core.sv
// Design: USB device core control with data FIFO
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Data FIFO
// ----------------------------------------------------------------------
module udcc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    output logic [WIDTH-1:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = wr_valid_i && wr_ready_o;
    wire pop = rd_valid_o && rd_ready_i;
    assign wr_ready_o = (cnt_q != DEPTH[AW:0]);
    assign rd_valid_o = (cnt_q != '0);
    assign rd_data_o = mem[rp_q];

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wp_q] <= wr_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (flush_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// ----------------------------------------------------------------------
// Core control
// ----------------------------------------------------------------------
module udcc_core (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic end_of_reset_i,
    input wire logic macro_enable_i,
    input wire logic clock_freeze_i,
    input wire logic low_speed_select_i,
    input wire logic detach_i,
    input wire logic vbus_i,
    input wire logic dp_i,
    input wire logic dm_i,
    input wire logic line_wake_clear_i,
    input wire logic vbus_change_clear_i,
    input wire logic [udcc_pkg::GEN_W-1:0] gen_event_i,
    input wire logic [udcc_pkg::GEN_W-1:0] gen_clear_i,
    input wire logic [udcc_pkg::GEN_W-1:0] gen_enable_i,
    input wire logic [udcc_pkg::NUM_EP*udcc_pkg::EP_FLAG_W-1:0] ep_event_i,
    input wire logic [udcc_pkg::NUM_EP*udcc_pkg::EP_FLAG_W-1:0] ep_clear_i,
    input wire logic [udcc_pkg::NUM_EP*udcc_pkg::EP_FLAG_W-1:0] endpoint_event_enables_i,
    input wire logic [udcc_pkg::FIFO_W-1:0] rx_data_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    output logic [udcc_pkg::FIFO_W-1:0] cpu_data_o,
    output logic cpu_valid_o,
    input wire logic cpu_ready_i,
    output logic [udcc_pkg::NUM_EP*udcc_pkg::EP_FLAG_W-1:0] endpoint_event_flags_o,
    output logic [udcc_pkg::NUM_EP-1:0] endpoint_irq_summary_o,
    output logic [udcc_pkg::GEN_W-1:0] gen_flags_o,
    output logic general_irq_o,
    output logic endpoint_irq_o,
    output logic cpu_wake_o,
    output logic pd_wake_o,
    output logic [1:0] state_o,
    output logic pad_suspend_o,
    output logic clock_gate_en_o,
    output logic pullup_dp_o,
    output logic pullup_dm_o,
    output logic bit_tick_o,
    output logic sample_tick_o
);
    localparam int EPW = udcc_pkg::NUM_EP * udcc_pkg::EP_FLAG_W;

    function automatic logic [udcc_pkg::GEN_W-1:0] flag_next(
        input logic [udcc_pkg::GEN_W-1:0] cur,
        input logic [udcc_pkg::GEN_W-1:0] set,
        input logic [udcc_pkg::GEN_W-1:0] clr);
        flag_next = (cur & ~clr) | set;
    endfunction

    // ------------------------------------------------------------------
    // Controller state
    // ------------------------------------------------------------------
    udcc_pkg::udcc_state_t state_q;
    udcc_pkg::udcc_state_t state_d;
    logic blk_rst;
    logic frozen;
    assign blk_rst = !macro_enable_i || end_of_reset_i;
    assign frozen = clock_freeze_i || state_q == udcc_pkg::UDCC_RESET;

    always_comb begin
        case (state_q)
            udcc_pkg::UDCC_RESET: state_d = macro_enable_i ? udcc_pkg::UDCC_IDLE
                                                            : udcc_pkg::UDCC_RESET;
            udcc_pkg::UDCC_IDLE: state_d = clock_freeze_i ? udcc_pkg::UDCC_IDLE
                                                          : udcc_pkg::UDCC_ACTIVE;
            udcc_pkg::UDCC_ACTIVE: state_d = clock_freeze_i ? udcc_pkg::UDCC_IDLE
                                                            : udcc_pkg::UDCC_ACTIVE;
            default: state_d = udcc_pkg::UDCC_RESET;
        endcase
        if (!macro_enable_i) begin
            state_d = udcc_pkg::UDCC_RESET;
        end else if (end_of_reset_i) begin
            state_d = udcc_pkg::UDCC_IDLE;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= udcc_pkg::UDCC_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Line and VBUS change detection
    // ------------------------------------------------------------------
    // Edge detection uses this clock; in silicon it runs on the pad side
    logic dp_q;
    logic dm_q;
    logic vbus_q;
    logic line_change;
    logic vbus_change;
    assign line_change = (dp_i != dp_q) || (dm_i != dm_q);
    assign vbus_change = vbus_i != vbus_q;

    // No reset: these follow the pins through reset, so release
    // never shows a false edge against a reset value
    always_ff @(posedge clock_i) begin
        dp_q <= dp_i;
        dm_q <= dm_i;
        vbus_q <= vbus_i;
    end

    // ------------------------------------------------------------------
    // General flags
    // ------------------------------------------------------------------
    logic [udcc_pkg::GEN_W-1:0] gen_q;
    logic [udcc_pkg::GEN_W-1:0] gen_set;
    logic [udcc_pkg::GEN_W-1:0] gen_clr;
    logic [udcc_pkg::GEN_W-1:0] timed_mask;
    assign timed_mask = frozen ? '0 : ~udcc_pkg::GEN_W'(8'h03);
    always_comb begin
        gen_set = gen_event_i & timed_mask;
        gen_set[udcc_pkg::GEN_WAKE_BIT] = line_change && macro_enable_i;
        gen_set[udcc_pkg::GEN_VBUS_BIT] = vbus_change;
        gen_clr = gen_clear_i;
        gen_clr[udcc_pkg::GEN_WAKE_BIT] = line_wake_clear_i;
        gen_clr[udcc_pkg::GEN_VBUS_BIT] = vbus_change_clear_i;
    end

    // Vbus flag survives block reset so plug detection works while disabled
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            gen_q <= '0;
        end else begin
            gen_q <= flag_next(gen_q, gen_set, gen_clr);
            if (blk_rst) begin
                gen_q[udcc_pkg::GEN_W-1:udcc_pkg::GEN_VBUS_BIT+1] <= '0;
                gen_q[udcc_pkg::GEN_WAKE_BIT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Endpoint flags
    // ------------------------------------------------------------------
    logic [EPW-1:0] ep_q;
    logic [EPW-1:0] ep_hit;
    logic [udcc_pkg::NUM_EP-1:0] ep_sum;
    assign ep_hit = ep_q & endpoint_event_enables_i;
    always_comb begin
        for (int e = 0; e < udcc_pkg::NUM_EP; e++) begin
            ep_sum[e] = |ep_hit[e*udcc_pkg::EP_FLAG_W +: udcc_pkg::EP_FLAG_W];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ep_q <= '0;
        end else if (blk_rst) begin
            ep_q <= '0;
        end else begin
            ep_q <= (ep_q & ~ep_clear_i) | (frozen ? '0 : ep_event_i);
        end
    end

    // ------------------------------------------------------------------
    // Speed, pull-up and bit clock
    // ------------------------------------------------------------------
    logic [5:0] div_q;
    logic [5:0] div_max;
    logic run;
    logic bit_tick;
    logic line_edge;
    assign run = state_q == udcc_pkg::UDCC_ACTIVE;
    assign div_max = low_speed_select_i ? 6'(udcc_pkg::LS_DIV - 1)
                                        : 6'(udcc_pkg::FS_DIV - 1);
    assign line_edge = dp_i != dp_q;
    assign bit_tick = run && div_q == div_max;

    // Phase tracking: a data edge re-centres the divider
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else if (!run) begin
            div_q <= '0;
        end else if (line_edge) begin
            div_q <= {1'b0, div_max[5:1]};
        end else if (div_q == div_max) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic gen_irq_d;
    logic ep_irq_d;
    assign gen_irq_d = |(gen_q & gen_enable_i);
    assign ep_irq_d = |ep_sum && !frozen;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            general_irq_o <= 1'b0;
            endpoint_irq_o <= 1'b0;
            cpu_wake_o <= 1'b0;
            pd_wake_o <= 1'b0;
            state_o <= 2'h0;
            pad_suspend_o <= 1'b1;
            clock_gate_en_o <= 1'b0;
            pullup_dp_o <= 1'b0;
            pullup_dm_o <= 1'b0;
            bit_tick_o <= 1'b0;
            sample_tick_o <= 1'b0;
            endpoint_event_flags_o <= '0;
            endpoint_irq_summary_o <= '0;
            gen_flags_o <= '0;
        end else begin
            general_irq_o <= gen_irq_d;
            endpoint_irq_o <= ep_irq_d;
            cpu_wake_o <= gen_irq_d || ep_irq_d;
            pd_wake_o <= gen_q[udcc_pkg::GEN_WAKE_BIT]
                || gen_q[udcc_pkg::GEN_VBUS_BIT];
            state_o <= state_q;
            pad_suspend_o <= state_q != udcc_pkg::UDCC_ACTIVE;
            clock_gate_en_o <= macro_enable_i && !clock_freeze_i;
            pullup_dp_o <= macro_enable_i && !detach_i && vbus_i
                && low_speed_select_i;
            pullup_dm_o <= macro_enable_i && !detach_i && vbus_i
                && !low_speed_select_i;
            bit_tick_o <= bit_tick;
            sample_tick_o <= run && line_edge;
            endpoint_event_flags_o <= ep_q;
            endpoint_irq_summary_o <= ep_sum;
            gen_flags_o <= gen_q;
        end
    end

    // ------------------------------------------------------------------
    // Receive data FIFO, flushed on block reset
    // ------------------------------------------------------------------
    // Depth covers an eighth of the largest endpoint; RAM allocation is elsewhere
    // Ready ignores the active state; words offered earlier are dropped
    udcc_fifo #(
        .WIDTH(udcc_pkg::FIFO_W),
        .DEPTH(udcc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .flush_i(blk_rst),
        .wr_data_i(rx_data_i),
        .wr_valid_i(rx_valid_i && run),
        .wr_ready_o(rx_ready_o),
        .rd_data_o(cpu_data_o),
        .rd_valid_o(cpu_valid_o),
        .rd_ready_i(cpu_ready_i)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_disable_resets: assert property (@(posedge clock_i) disable iff (rst_i)
        !macro_enable_i |=> state_q == udcc_pkg::UDCC_RESET)
        else $error("state not reset after disable");
    a_enable_idle: assert property (@(posedge clock_i) disable iff (rst_i)
        state_q == udcc_pkg::UDCC_RESET && macro_enable_i && !end_of_reset_i
        |=> state_q == udcc_pkg::UDCC_IDLE)
        else $error("enable did not reach idle");
    a_eor_enabled: assert property (@(posedge clock_i) disable iff (rst_i)
        macro_enable_i && end_of_reset_i |=> state_q == udcc_pkg::UDCC_IDLE)
        else $error("end of reset left wrong state");
    a_vbus_flag_set: assert property (@(posedge clock_i) disable iff (rst_i)
        vbus_i != $past(vbus_i) |=> gen_q[udcc_pkg::GEN_VBUS_BIT])
        else $error("vbus change missed");
    a_wake_flag_set: assert property (@(posedge clock_i) disable iff (rst_i)
        macro_enable_i && !end_of_reset_i && line_change
        |=> gen_q[udcc_pkg::GEN_WAKE_BIT])
        else $error("line change missed");
    a_frozen_ep_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
        frozen |=> !endpoint_irq_o)
        else $error("endpoint irq while frozen");
    a_gen_irq_or: assert property (@(posedge clock_i) disable iff (rst_i)
        |(gen_q & gen_enable_i) |=> general_irq_o)
        else $error("general irq missing");
    a_pullup_excl: assert property (@(posedge clock_i) disable iff (rst_i)
        !(pullup_dp_o && pullup_dm_o))
        else $error("both pull-ups on");
    a_pd_wake: assert property (@(posedge clock_i) disable iff (rst_i)
        gen_q[udcc_pkg::GEN_VBUS_BIT] |=> pd_wake_o)
        else $error("power-down wake missing");
    a_summary_ep: assert property (@(posedge clock_i) disable iff (rst_i)
        endpoint_irq_o |-> $past(|ep_sum))
        else $error("summary disagrees with irq");
endmodule

// >>> hdl/udcc_pkg.sv
// Package: constants for the USB device core control block
package udcc_pkg;
    // ------------------------------------------------------------------
    // Endpoint flag layout
    // ------------------------------------------------------------------
    localparam int NUM_EP = 7;
    localparam int EP_FLAG_W = 8;
    localparam int NAK_IN_BIT = 6;
    localparam int OUT_RX_BIT = 2;
    localparam int STALL_BIT = 1;
    // ------------------------------------------------------------------
    // General event flag layout
    // ------------------------------------------------------------------
    localparam int GEN_W = 8;
    localparam int GEN_WAKE_BIT = 0;
    localparam int GEN_VBUS_BIT = 1;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_MACRO_ENABLE = 1'b0;
    localparam logic RST_CLOCK_FREEZE = 1'b1;
    // ------------------------------------------------------------------
    // Clocking and memory budget
    // ------------------------------------------------------------------
    localparam int REF_CLK_KHZ = 48000;
    localparam int FS_BIT_KHZ = 12000;
    localparam int LS_BIT_KHZ = 1500;
    localparam int FS_DIV = REF_CLK_KHZ / FS_BIT_KHZ;
    localparam int LS_DIV = REF_CLK_KHZ / LS_BIT_KHZ;
    localparam int EP_RAM_BYTES = 832;
    localparam int EP0_MAX = 64;
    localparam int EP1_MAX = 256;
    localparam int EPN_MAX = 64;
    localparam int FIFO_W = 8;
    localparam int FIFO_DEPTH = 32;
    // ------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {UDCC_RESET, UDCC_IDLE, UDCC_ACTIVE} udcc_state_t;
endpackage

// >>> tb/udcc_host_model.sv
// Host side model: bus supply, data lines and receive stream
`timescale 1ns/1ns

module udcc_host_model (
    input wire logic clock_i,
    input wire logic rx_ready_i,
    output logic vbus_o,
    output logic dp_o,
    output logic dm_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o
);
    // ------------------------------------------------------------------
    // Line state
    // ------------------------------------------------------------------
    initial begin
        vbus_o = 1'b0;
        dp_o = 1'b1;
        dm_o = 1'b0;
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
    end

    // Every level change is a transition the device must flag
    task automatic set_vbus(input logic v);
        vbus_o = v;
    endtask

    // Flip both lines between J and K
    task automatic toggle_lines();
        dp_o = ~dp_o;
        dm_o = ~dm_o;
    endtask

    // ------------------------------------------------------------------
    // Stream push, held until accepted
    // ------------------------------------------------------------------
    // Called just after an edge; ready is read settled, before the taking edge
    // Valid stays up between back-to-back words, so it never toggles in one step
    task automatic push(input logic [7:0] d);
        logic w;
        rx_data_o = d;
        rx_valid_o = 1'b1;
        w = 1'b0;
        while (!w) begin
            w = rx_ready_i;
            @(posedge clock_i);
            #10;
        end
    endtask

    task automatic push_end();
        rx_valid_o = 1'b0;
        rx_data_o = ~rx_data_o; // Released data must not look valid
    endtask
endmodule

// >>> tb/usb_device_core_control_bench.sv
// Self-checking bench for the device core control block
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module usb_device_core_control_bench;
    localparam int EPW = udcc_pkg::NUM_EP * udcc_pkg::EP_FLAG_W;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic eor = 1'b0, men = 1'b0, frz = 1'b1, lss = 1'b0, det = 1'b1;
    logic wclr = 1'b0, vclr = 1'b0, cpu_ready = 1'b0;
    logic [udcc_pkg::GEN_W-1:0] gev = '0, gclr = '0, gen = '0;
    logic [EPW-1:0] eev = '0, eclr = '0, een = '0;
    logic vbus, dp, dm, rx_valid, rx_ready, cpu_valid, gen_irq, ep_irq, cpu_wake, pd_wake;
    logic pad_susp, cg_en, pu_dp, pu_dm, bit_tick, stick;
    logic [7:0] rx_data, cpu_data, gflags;
    logic [EPW-1:0] eflags;
    logic [udcc_pkg::NUM_EP-1:0] esum;
    logic [1:0] state;
    int n_errors = 0, compares = 0, cycles = 0;

    always #50 clock_i = ~clock_i;

    udcc_host_model HOST (.clock_i(clock_i), .rx_ready_i(rx_ready), .vbus_o(vbus), .dp_o(dp),
        .dm_o(dm), .rx_data_o(rx_data), .rx_valid_o(rx_valid));

    udcc_core DUT (.clock_i(clock_i), .rst_i(rst_i), .end_of_reset_i(eor), .macro_enable_i(men),
        .clock_freeze_i(frz), .low_speed_select_i(lss), .detach_i(det), .vbus_i(vbus),
        .dp_i(dp), .dm_i(dm), .line_wake_clear_i(wclr), .vbus_change_clear_i(vclr),
        .gen_event_i(gev), .gen_clear_i(gclr), .gen_enable_i(gen), .ep_event_i(eev),
        .ep_clear_i(eclr), .endpoint_event_enables_i(een), .rx_data_i(rx_data),
        .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .cpu_data_o(cpu_data),
        .cpu_valid_o(cpu_valid), .cpu_ready_i(cpu_ready), .endpoint_event_flags_o(eflags),
        .endpoint_irq_summary_o(esum), .gen_flags_o(gflags), .general_irq_o(gen_irq),
        .endpoint_irq_o(ep_irq), .cpu_wake_o(cpu_wake), .pd_wake_o(pd_wake), .state_o(state),
        .pad_suspend_o(pad_susp), .clock_gate_en_o(cg_en), .pullup_dp_o(pu_dp),
        .pullup_dm_o(pu_dm), .bit_tick_o(bit_tick), .sample_tick_o(stick));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic end_of_test();
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Longest legitimate run is a few hundred cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #10;
    endtask

    task automatic wait_state(input logic [1:0] s);
        int i;
        for (i = 0; i < 50 && state !== s; i++) step(1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        `CHK(state, 2'h0)
        `CHK(pad_susp, 1'b1)
        `CHK({gen_irq, ep_irq, pu_dp, pu_dm, cg_en}, 5'h00)
        rst_i = 1'b0;
        step(3);
        `CHK(state, 2'h0)
        men = 1'b1;
        wait_state(2'h1);
        `CHK(state, 2'h1)
    endtask

    task automatic t_frozen();
        frz = 1'b1;
        gen = 8'h07;
        gev = 8'h04;
        eev[3] = 1'b1;
        een[3] = 1'b1;
        step(1);
        gev = 8'h00;
        eev = '0;
        step(3);
        `CHK({gflags[2], eflags[3], ep_irq}, 3'h0)
        `CHK(cg_en, 1'b0)
        HOST.set_vbus(1'b1);
        step(3);
        `CHK({gflags[1], pd_wake, gen_irq, cpu_wake}, 4'hf)
        vclr = 1'b1;
        step(1);
        vclr = 1'b0;
        step(3);
        `CHK({gflags[1], gen_irq}, 2'h0)
        HOST.toggle_lines();
        step(3);
        `CHK({gflags[0], pd_wake, gen_irq}, 3'h7)
        wclr = 1'b1;
        step(1);
        wclr = 1'b0;
        step(3);
        `CHK({gflags[0], pd_wake}, 2'h0)
    endtask

    task automatic t_general();
        frz = 1'b0;
        gen = 8'h00;
        gev = 8'h20;
        step(1);
        gev = 8'h00;
        step(3);
        `CHK({gflags[5], gen_irq}, 2'h2)
        `CHK(cg_en, 1'b1)
        gen = 8'h20;
        step(3);
        `CHK({gen_irq, cpu_wake, ep_irq}, 3'h6)
        gclr = 8'h20;
        step(1);
        gclr = 8'h00;
        step(3);
        `CHK({gflags[5], gen_irq}, 2'h0)
    endtask

    task automatic t_endpoint();
        int b;
        for (b = 0; b < udcc_pkg::EP_FLAG_W; b++) begin
            een = '0;
            een[3*8+b] = 1'b1;
            eev[3*8+b] = 1'b1;
            step(1);
            eev = '0;
            step(3);
            `CHK(eflags[3*8+b], 1'b1)
            `CHK(esum, 7'h08)
            `CHK({ep_irq, gen_irq}, 2'h2)
            eclr[3*8+b] = 1'b1;
            step(1);
            eclr = '0;
            step(3);
            `CHK(ep_irq, 1'b0)
        end
        een = '0;
        een[5*8+udcc_pkg::NAK_IN_BIT] = 1'b1;
        eev[5*8+udcc_pkg::OUT_RX_BIT] = 1'b1;
        eev[5*8+udcc_pkg::STALL_BIT] = 1'b1;
        step(1);
        eev = '0;
        step(3);
        `CHK(eflags[5*8 +: 8], 8'h06)
        `CHK(ep_irq, 1'b0)
    endtask

    task automatic t_speed();
        det = 1'b0;
        lss = 1'b1;
        step(3);
        `CHK({pu_dp, pu_dm}, 2'h2)
        lss = 1'b0;
        step(3);
        `CHK({pu_dp, pu_dm}, 2'h1)
        det = 1'b1;
        step(3);
        `CHK({pu_dp, pu_dm}, 2'h0)
        det = 1'b0;
    endtask

    task automatic t_tick(input logic ls, input int div);
        int i, n;
        lss = ls;
        step(2);
        for (i = 0; i < 100 && bit_tick !== 1'b1; i++) step(1);
        n = 0;
        step(1);
        for (i = 0; i < 100 && bit_tick !== 1'b1; i++) begin
            step(1);
            n++;
        end
        `CHK(n + 1, div)
        HOST.toggle_lines();
        step(1);
        `CHK({stick, bit_tick}, 2'h2)
        for (n = 0; n < 100 && bit_tick !== 1'b1; n++) step(1);
        `CHK(n, div - (div - 1) / 2)
    endtask

    task automatic t_fifo();
        int i;
        HOST.toggle_lines();
        wait_state(2'h2);
        `CHK(state, 2'h2)
        for (i = 0; i < udcc_pkg::FIFO_DEPTH; i++) HOST.push(8'h40 + 8'(i));
        HOST.push_end();
        step(1);
        `CHK({rx_ready, cpu_valid}, 2'h1)
        for (i = 0; i < udcc_pkg::FIFO_DEPTH; i++) begin
            `CHK(cpu_data, 8'h40 + 8'(i))
            cpu_ready = 1'b1;
            step(1);
        end
        cpu_ready = 1'b0;
        `CHK({cpu_valid, rx_ready}, 2'h1)
    endtask

    task automatic t_resets();
        eev[8] = 1'b1;
        step(1);
        eev = '0;
        step(3);
        `CHK(eflags[8], 1'b1)
        men = 1'b0;
        step(3);
        `CHK({state, pad_susp, eflags[8]}, 4'h2)
        men = 1'b1;
        wait_state(2'h1);
        eev[8] = 1'b1;
        step(1);
        eev = '0;
        eor = 1'b1;
        step(1);
        `CHK(eflags[8], 1'b1)
        eor = 1'b0;
        step(1);
        `CHK({state, eflags[8]}, 3'h2)
        rst_i = 1'b1;
        #10 `CHK({state, pad_susp, gflags[7:2]}, 9'h040)
        step(2);
        rst_i = 1'b0;
        step(2);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        step(2);
        t_reset();
        t_frozen();
        t_general();
        t_endpoint();
        t_speed();
        t_fifo();
        t_tick(1'b0, udcc_pkg::FS_DIV);
        t_tick(1'b1, udcc_pkg::LS_DIV);
        t_resets();
        end_of_test();
    end
endmodule
